// ---- ext_mem_pkg.sv ----
// Constants and carrier types of the external memory bus interface
`default_nettype none
package ext_mem_pkg;
    // ==========================================
    // Register map (byte addresses on the bus)
    localparam int BUS_ADDR_W = 12;
    localparam logic [11:0] CFG_ONE_IDX = 12'h00F5; // Printed index
    localparam logic [11:0] CFG_ONE_ADDR = {CFG_ONE_IDX[9:0], 2'b00};
    localparam logic [11:0] STRETCH_ADDR = 12'h03D8; // Strobe stretch fields
    localparam logic [11:0] CTRL_ADDR = 12'h03DC; // Loose control bits
    localparam logic [11:0] STATUS_ADDR = 12'h03E0; // Engine state
    localparam logic [11:0] TARGET_ADDR = 12'h03E4; // Cycle address
    localparam logic [11:0] COMMAND_ADDR = 12'h03E8; // Starts a cycle
    localparam logic [11:0] READ_DATA_ADDR = 12'h03EC; // Last read byte
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================
    // First configuration register
    localparam logic [7:0] CFG_ONE_RESET = 8'h80;
    localparam logic [7:0] CFG_ONE_WMASK = 8'h76; // Reserved bits fixed
    localparam int FORMAT_BIT = 6;
    localparam int SECOND_EN_BIT = 5;
    localparam int STROBE_ALT_BIT = 4;
    localparam int TOGGLE_BIT = 2;
    localparam int DRIVE_BIT = 1;
    // ==========================================
    // Control register bits
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int FLOAT_BIT = 0;
    localparam int WAIT_EN_BIT = 1;
    localparam int PORT0_ALT_BIT = 2;
    localparam int PORT1_ALT_BIT = 3;
    localparam int PORT9_ALT_BIT = 4;
    localparam int SERIAL_PE_BIT = 5;
    localparam logic [5:0] SHARED_PIN_MASK = 6'h06; // Upper pins 2:1
    // ==========================================
    // Command word and cycle shape
    localparam int CMD_READ_BIT = 8;
    localparam int CMD_INT_BIT = 9;
    localparam int ADDR_W = 22;
    localparam logic [9:0] STRETCH_RESET = 10'h3FF;
    localparam logic [3:0] PHASE_LAST = 4'h1; // Two cycles per phase
    // ==========================================
    // Types
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_DATA = 2'b10
    } bus_state_e;
    typedef struct packed {
        logic [2:0] upper_data_strobe_stretch;
        logic [2:0] lower_data_strobe_stretch;
        logic [1:0] upper_addr_strobe_stretch;
        logic [1:0] lower_addr_strobe_stretch;
    } stretch_s;
    typedef struct packed {
        logic address_strobe_n;
        logic data_strobe_n;
        logic read_write;
        logic second_data_strobe_n;
    } strobe_s;
    localparam strobe_s STROBE_IDLE = 4'hF;
endpackage : ext_mem_pkg
`default_nettype wire

// ---- external_memory_bus_interface.sv ----
// External multiplexed memory bus engine with an AXI4-Lite register slave
//
// Behaviour
// - Each cycle: address phase then data phase
// - Address driven in address phase, held after
// - Reads float data port, take byte of next-to-last strobe cycle
// - Write data driven in data phase, held
// - Data strobe only for external accesses
// - Address strobe low inside address phase
// - Strobes float on bus acknowledge or request
// - Strobes undriven, pulled high, during reset
// - Read/write high read, low write, stable
// - Top address bit picks block; internal keeps high
// - Port zero carries low address then data
// - Second port carries middle address byte
// - Third port upper pins carry top address
// - Shared pins lost while serial controller enabled
// - Wait input sampled each cycle, adds cycles
// - Wait stretches the strobe of current phase
// - Format bit turns address strobe into latch enable
// - Latch mode: output enable and write enable
// - Second strobe serves lower block when enabled
// - Alternate enable gates port-borne address strobe
// - Address stretch adds zero to three cycles
// - Data stretch adds zero to seven cycles
`timescale 1ns/1ps
`default_nettype none
module external_memory_bus_interface
    import ext_mem_pkg::*;
#(
    parameter bit STROBE_ON_PORT = 1'b1, // Strobe is a port function
    parameter bit MMU_PRESENT = 1'b1, // Top address port exists
    parameter bit LARGE_MEMBER = 1'b0 // Shares pins with serial bus
)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [BUS_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [BUS_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic [7:0] ad_out,
    output logic ad_oe,
    input wire logic [7:0] ad_in,
    output logic [7:0] addr_mid_out,
    output logic addr_mid_oe,
    output logic [5:0] addr_high_out,
    output logic [5:0] addr_high_oe,
    output strobe_s strobe_out,
    output strobe_s strobe_oe,
    input wire logic wait_n,
    input wire logic bus_ack,
    output logic high_drive
);
    // ==========================================
    // Declarations
    logic [7:0] cfg_one; // Format, second strobe, alt enable
    stretch_s stretch; // Stretch fields
    logic [7:0] ctrl; // Float, wait enable, port functions
    logic [ADDR_W-1:0] target; // Address of next cycle
    logic [7:0] read_data; // Byte caught at last external read
    logic done; // A cycle has completed
    logic launch; // Cycle accepted, not yet started
    bus_state_e state;
    bus_state_e next_state;
    logic [3:0] cnt; // Cycles left in phase
    logic [3:0] next_cnt;
    logic [ADDR_W-1:0] cyc_addr; // Latched cycle fields
    logic [7:0] cyc_data;
    logic cyc_read;
    logic cyc_int;
    logic cyc_fmt;
    logic cyc_ds2;
    logic wait_s1; // Pin synchronisers
    logic wait_s2;
    logic ack_s1;
    logic ack_s2;
    logic [7:0] ad_s1;
    logic [7:0] ad_s2;
    logic waiting; // Wait sampled active
    logic upper; // Upper memory block addressed
    logic toggle; // Pins follow this cycle
    logic active; // Data strobe pulse wanted
    logic wr_go; // Write taken this edge
    logic rd_go; // Read taken this edge
    logic wr_hit;
    logic rd_hit;
    logic start;
    logic phase_end;
    logic [31:0] rd_word;
    logic capture; // Read byte due from the synchroniser

    // ==========================================
    // Pin synchronisers
    // Two flops on every pin input
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wait_s1 <= 1'b1;
            wait_s2 <= 1'b1;
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
            ad_s1 <= 8'h00;
            ad_s2 <= 8'h00;
        end
        else
        begin
            wait_s1 <= wait_n;
            wait_s2 <= wait_s1;
            ack_s1 <= bus_ack;
            ack_s2 <= ack_s1;
            ad_s1 <= ad_in;
            ad_s2 <= ad_s1;
        end
    end

    // Wait counts only when enabled
    assign waiting = ctrl[WAIT_EN_BIT] & ~wait_s2;
    // Top address bit selects the block
    assign upper = cyc_addr[ADDR_W-1];
    // Internal cycles move pins only if toggling
    assign toggle = ~cyc_int | cfg_one[TOGGLE_BIT];
    // Output enable in latch mode only on reads
    assign active = ~cyc_int & (~cyc_fmt | cyc_read);
    assign phase_end = (cnt == 4'h0) & ~waiting;
    assign wr_go = awready & awvalid;
    assign rd_go = arready & arvalid;
    assign start = wr_go & (awaddr == COMMAND_ADDR) & wstrb[1] & ~launch & (state == ST_IDLE);

    // ==========================================
    // Write channel
    // Address and data taken together
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            awready <= 1'b0;
            wready <= 1'b0;
        end
        else
        begin
            awready <= awvalid & wvalid & ~awready & ~bvalid;
            wready <= awvalid & wvalid & ~awready & ~bvalid;
        end
    end

    // Known write addresses
    always_comb
    begin
        case (awaddr)
            CFG_ONE_ADDR, STRETCH_ADDR, CTRL_ADDR, TARGET_ADDR, COMMAND_ADDR: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // Write response
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end
        else if (wr_go)
        begin
            bvalid <= 1'b1;
            bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (bready)
        begin
            bvalid <= 1'b0;
        end
    end

    // ==========================================
    // Software registers
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cfg_one <= CFG_ONE_RESET;
            stretch <= STRETCH_RESET;
            ctrl <= CTRL_RESET;
            target <= '0;
        end
        else if (wr_go)
        begin
            case (awaddr)
                CFG_ONE_ADDR:
                begin
                    // Reserved bits keep fixed values
                    if (wstrb[0])
                        cfg_one <= (wdata[7:0] & CFG_ONE_WMASK) | (CFG_ONE_RESET & ~CFG_ONE_WMASK);
                end
                STRETCH_ADDR:
                begin
                    if (&wstrb[1:0])
                        stretch <= wdata[9:0];
                end
                CTRL_ADDR:
                begin
                    if (wstrb[0])
                        ctrl <= wdata[7:0];
                end
                TARGET_ADDR:
                begin
                    if (&wstrb[2:0])
                        target <= wdata[ADDR_W-1:0];
                end
                default:
                begin
                    cfg_one <= cfg_one;
                end
            endcase
        end
    end

    // ==========================================
    // Read channel
    always_comb
    begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        case (araddr)
            CFG_ONE_ADDR: rd_word[7:0] = cfg_one;
            STRETCH_ADDR: rd_word[9:0] = stretch;
            CTRL_ADDR: rd_word[7:0] = ctrl;
            // Phase, wait, done, busy
            STATUS_ADDR: rd_word[4:0] = {state, waiting, done, launch | (state != ST_IDLE)};
            TARGET_ADDR: rd_word[ADDR_W-1:0] = target;
            COMMAND_ADDR: rd_word[9:0] = {cyc_int, cyc_read, cyc_data};
            READ_DATA_ADDR: rd_word[7:0] = read_data;
            default: rd_hit = 1'b0;
        endcase
    end

    // Read address accept and data answer
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end
        else
        begin
            arready <= arvalid & ~arready & ~rvalid;
            if (rd_go)
            begin
                rvalid <= 1'b1;
                rdata <= rd_word;
                rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (rready)
            begin
                rvalid <= 1'b0;
            end
        end
    end

    // ==========================================
    // Cycle latch
    // Fields frozen for the whole cycle
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            launch <= 1'b0;
            cyc_addr <= '0;
            cyc_data <= 8'h00;
            cyc_read <= 1'b1;
            cyc_int <= 1'b0;
            cyc_fmt <= 1'b0;
            cyc_ds2 <= 1'b0;
        end
        else if (start)
        begin
            launch <= 1'b1;
            cyc_addr <= target;
            cyc_data <= wdata[7:0];
            cyc_read <= wdata[CMD_READ_BIT];
            cyc_int <= wdata[CMD_INT_BIT];
            cyc_fmt <= cfg_one[FORMAT_BIT];
            cyc_ds2 <= cfg_one[SECOND_EN_BIT];
        end
        else if (state == ST_IDLE)
        begin
            launch <= 1'b0;
        end
    end

    // ==========================================
    // Phase sequencer
    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        case (state)
            ST_IDLE:
            begin
                // Address phase plus its stretch
                if (launch)
                begin
                    next_state = ST_ADDR;
                    next_cnt = PHASE_LAST;
                    if (!cyc_int)
                        next_cnt = PHASE_LAST + {2'b00, upper ? stretch.upper_addr_strobe_stretch
                                                              : stretch.lower_addr_strobe_stretch};
                end
            end
            ST_ADDR:
            begin
                // Wait holds the count
                if (phase_end)
                begin
                    next_state = ST_DATA;
                    next_cnt = PHASE_LAST;
                    if (!cyc_int)
                        next_cnt = PHASE_LAST + {1'b0, upper ? stretch.upper_data_strobe_stretch
                                                             : stretch.lower_data_strobe_stretch};
                end
                else if (!waiting)
                    next_cnt = cnt - 4'h1;
            end
            ST_DATA:
            begin
                if (phase_end)
                    next_state = ST_IDLE;
                else if (!waiting)
                    next_cnt = cnt - 4'h1;
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // State and count
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state <= ST_IDLE;
            cnt <= 4'h0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    // Read capture one cycle after the strobe rising edge
    // The pin synchroniser lags, so this byte stood on the port while the strobe was low
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            read_data <= 8'h00;
            done <= 1'b0;
            capture <= 1'b0;
        end
        else
        begin
            capture <= (state == ST_DATA) && phase_end && cyc_read && !cyc_int;
            // Byte from the next-to-last data cycle
            if (capture)
                read_data <= ad_s2;
            if (state == ST_DATA && phase_end)
                done <= 1'b1;
            else if (start)
                done <= 1'b0;
        end
    end

    // ==========================================
    // Bus pins
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            strobe_out <= STROBE_IDLE;
            ad_out <= 8'h00;
            ad_oe <= 1'b0;
            addr_mid_out <= 8'h00;
            addr_high_out <= 6'h00;
        end
        else
        begin
            case (next_state)
                ST_ADDR:
                begin
                    strobe_out.data_strobe_n <= 1'b1;
                    strobe_out.second_data_strobe_n <= 1'b1;
                    if (toggle)
                    begin
                        // Standard strobe falls after first cycle
                        strobe_out.address_strobe_n <= cyc_fmt | (state != ST_ADDR);
                        if (state == ST_IDLE)
                        begin
                            ad_out <= cyc_addr[7:0];
                            ad_oe <= ctrl[PORT0_ALT_BIT];
                            addr_mid_out <= cyc_addr[15:8];
                            addr_high_out <= cyc_addr[ADDR_W-1:16];
                            // Direction set at cycle start
                            strobe_out.read_write <= cyc_fmt | cyc_read;
                        end
                    end
                end
                ST_DATA:
                begin
                    // Second strobe takes lower block
                    strobe_out.data_strobe_n <= ~(active & ~(cyc_ds2 & ~upper));
                    strobe_out.second_data_strobe_n <= ~(active & cyc_ds2 & ~upper);
                    if (toggle)
                    begin
                        strobe_out.address_strobe_n <= ~cyc_fmt;
                        if (cyc_fmt)
                            strobe_out.read_write <= cyc_read;
                        if (state == ST_ADDR)
                        begin
                            // Read floats, write drives data
                            ad_oe <= ~cyc_read & ctrl[PORT0_ALT_BIT];
                            if (!cyc_read)
                                ad_out <= cyc_data;
                        end
                    end
                end
                ST_IDLE:
                begin
                    // Data port holds; direction holds unless the format bit is set
                    strobe_out.data_strobe_n <= 1'b1;
                    strobe_out.second_data_strobe_n <= 1'b1;
                    strobe_out.address_strobe_n <= ~cfg_one[FORMAT_BIT];
                    if (cfg_one[FORMAT_BIT])
                        strobe_out.read_write <= 1'b1;
                end
                default:
                begin
                    strobe_out <= STROBE_IDLE;
                end
            endcase
        end
    end

    // Pin enables; released in reset for pull-ups
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            strobe_oe <= 4'h0;
            addr_mid_oe <= 1'b0;
            addr_high_oe <= 6'h00;
            high_drive <= 1'b0;
        end
        else
        begin
            if (ctrl[FLOAT_BIT] || ack_s2)
                strobe_oe <= 4'h0;
            else
            begin
                strobe_oe <= STROBE_IDLE;
                strobe_oe.address_strobe_n <= ~STROBE_ON_PORT | cfg_one[STROBE_ALT_BIT];
            end
            addr_mid_oe <= ctrl[PORT1_ALT_BIT];
            // Shared pins drop while serial bus is on
            addr_high_oe <= {6{MMU_PRESENT & ctrl[PORT9_ALT_BIT]}}
                          & ~((LARGE_MEMBER & ctrl[SERIAL_PE_BIT]) ? SHARED_PIN_MASK : 6'h00);
            high_drive <= cfg_one[DRIVE_BIT];
        end
    end

    // ==========================================
    // Assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_addr_to_data: assert property (state == ST_ADDR && phase_end |=> state == ST_DATA)
        else $error("address phase did not hand over");
    a_wait_holds: assert property (state != ST_IDLE && waiting |=> state == $past(state) && cnt == $past(cnt))
        else $error("wait did not hold the phase");
    a_float_all: assert property (ctrl[FLOAT_BIT] |=> strobe_oe == 4'h0)
        else $error("strobes driven while float requested");
    a_read_float: assert property (state == ST_DATA && cyc_read && toggle |-> !ad_oe)
        else $error("data port driven during read");
    a_internal_quiet: assert property (state == ST_DATA && cyc_int |-> strobe_out.data_strobe_n && strobe_out.second_data_strobe_n)
        else $error("data strobe on internal cycle");
    a_dir_stable: assert property (state == ST_DATA && !cyc_fmt && !cyc_int |-> strobe_out.read_write == cyc_read)
        else $error("direction wrong in data phase");
    a_upper_second: assert property (state == ST_DATA && cyc_ds2 && upper |-> strobe_out.second_data_strobe_n)
        else $error("second strobe on upper block");
    a_latch_high: assert property (state == ST_ADDR && cyc_fmt && toggle |-> strobe_out.address_strobe_n)
        else $error("latch enable low in address phase");
    a_strobe_low: assert property (state == ST_DATA && !cyc_fmt && !cyc_int && !cyc_ds2 |-> !strobe_out.data_strobe_n ##1 1)
        else $error("data strobe idle in external cycle");
    a_addr_length: assert property ($rose(state == ST_ADDR) && !cyc_int && !cyc_fmt && !upper && stretch.lower_addr_strobe_stretch == 2'h0 && !ctrl[WAIT_EN_BIT] |-> ##2 state == ST_DATA)
        else $error("unstretched address phase length wrong");
endmodule : external_memory_bus_interface
`default_nettype wire

// ---- ext_mem_model.sv ----
// Behavioural external memory behind the multiplexed bus
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model
    import ext_mem_pkg::*;
(
    input wire logic clk_sys,
    input wire strobe_s pins,
    input wire logic [7:0] ad_out,
    input wire logic ad_oe,
    input wire logic [7:0] addr_mid_out,
    output logic [7:0] ad_in
);
    // ====
    // Storage, latched address, strobe counters
    logic [7:0] mem [0:65535];
    logic [15:0] addr_q;
    logic rw_seen;
    int as_cnt = 0;
    int ds_cnt = 0;
    int ds_falls = 0;
    int ds2_falls = 0;
    // Latch address as the address strobe falls
    always @(negedge pins.address_strobe_n) addr_q = {addr_mid_out, ad_out};
    // Note the direction as the data strobe falls
    always @(negedge pins.data_strobe_n)
    begin
        ds_falls = ds_falls + 1;
        rw_seen = pins.read_write;
    end
    // Count second strobe pulses
    always @(negedge pins.second_data_strobe_n) ds2_falls = ds2_falls + 1;
    // Take write data at the strobe's end
    always @(posedge pins.data_strobe_n) if (pins.read_write === 1'b0) mem[addr_q] = ad_out;
    // Low time of both strobes, in clocks
    always @(posedge clk_sys)
    begin
        if (pins.address_strobe_n === 1'b0) as_cnt <= as_cnt + 1;
        if (pins.data_strobe_n === 1'b0) ds_cnt <= ds_cnt + 1;
    end
    // Drive only while the device floats, else a changing pattern
    assign ad_in = (!(pins.data_strobe_n && pins.second_data_strobe_n) && pins.read_write && !ad_oe) ? mem[addr_q]
                 : ~ad_out;
endmodule : ext_mem_model
`default_nettype wire

// ---- external_memory_bus_interface_bench.sv ----
// Self-checking bench of the external memory bus interface
`timescale 1ns/1ps
`default_nettype none
module external_memory_bus_interface_bench
    import ext_mem_pkg::*;
;
    // ====
    // Bus and pin signals
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [11:0] awaddr = '0;
    logic [11:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic bus_ack = 1'b0;
    logic wait_n = 1'b1;
    logic awready, wready, bvalid, arready, rvalid, ad_oe, high_drive, addr_mid_oe;
    logic [5:0] addr_high_out, addr_high_oe;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, v;
    logic [7:0] ad_out, ad_in, addr_mid_out;
    strobe_s strobe_out, strobe_oe, pins;
    int a0, d0, f0;
    int error_cnt = 0;
    int cmp_count = 0;
    always #5 clk_sys = ~clk_sys;
    // Undriven strobe pins rise to their pull-ups
    assign pins = strobe_out | ~strobe_oe;
    external_memory_bus_interface i_external_memory_bus_interface (
        .clk_sys, .sys_rst, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp,
        .bvalid, .bready(1'b1), .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready(1'b1), .ad_out,
        .ad_oe, .ad_in, .addr_mid_out, .addr_mid_oe, .addr_high_out, .addr_high_oe, .strobe_out,
        .strobe_oe, .wait_n, .bus_ack, .high_drive
    );
    ext_mem_model i_ext_mem_model (.clk_sys, .pins, .ad_out, .ad_oe, .addr_mid_out, .ad_in);
    // Compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    // Register write, both channels released on their own ready
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bit ok;
        ok = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!ok)
        begin
            @(posedge clk_sys);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            ok = (bvalid === 1'b1);
            r = bresp;
        end
    endtask : wr
    // Register read into v and r
    task automatic rd(input logic [11:0] a);
        bit ok;
        ok = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        while (!ok)
        begin
            @(posedge clk_sys);
            if (arready === 1'b1) arvalid <= 1'b0;
            ok = (rvalid === 1'b1);
            v = rdata;
            r = rresp;
        end
    endtask : rd
    // Start a memory cycle and poll until done and idle
    task automatic cyc(input logic [31:0] cmd);
        a0 = i_ext_mem_model.as_cnt;
        d0 = i_ext_mem_model.ds_cnt;
        f0 = i_ext_mem_model.ds_falls;
        wr(COMMAND_ADDR, cmd);
        repeat (4) @(posedge clk_sys);
        v = '0;
        while (v[1:0] !== 2'b10) rd(STATUS_ADDR);
    endtask : cyc
    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results
    initial
    begin
        #100000;
        error_cnt++;
        results();
    end
    initial
    begin
        i_ext_mem_model.mem[16'h0055] = 8'h3C;
        i_ext_mem_model.mem[16'h00AA] = 8'hC3;
        repeat (2) @(posedge clk_sys);
        check(strobe_oe, 4'h0);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        rd(CFG_ONE_ADDR);
        check(v, 32'h0000_0080);
        check(strobe_oe, 4'h7);
        rd(STRETCH_ADDR);
        check(v, 32'h0000_03FF);
        rd(12'h000);
        check(r, RESP_SLVERR);
        wr(CFG_ONE_ADDR, 32'h0000_00FF);
        rd(CFG_ONE_ADDR);
        check(v, 32'h0000_00F6);
        check(high_drive, 1'b1);
        wr(CFG_ONE_ADDR, 32'h0000_0010);
        wr(STRETCH_ADDR, 32'h0000_0021);
        wr(CTRL_ADDR, 32'h0000_001C);
        wr(TARGET_ADDR, 32'h0000_1234);
        check(strobe_oe.address_strobe_n, 1'b1);
        $display("registers done");
        cyc(32'h0000_00A5);
        check(i_ext_mem_model.mem[16'h1234], 8'hA5);
        check(i_ext_mem_model.rw_seen, 1'b0);
        check(i_ext_mem_model.as_cnt - a0, 2);
        check(i_ext_mem_model.ds_cnt - d0, 4);
        cyc(32'h0000_0100);
        rd(READ_DATA_ADDR);
        check(v, 32'h0000_00A5);
        check(i_ext_mem_model.rw_seen, 1'b1);
        check(i_ext_mem_model.ds_falls - f0, 1);
        $display("external cycles done");
        cyc(32'h0000_0300);
        check(i_ext_mem_model.ds_falls - f0, 0);
        wr(CFG_ONE_ADDR, 32'h0000_0030);
        cyc(32'h0000_0100);
        check(i_ext_mem_model.ds_falls - f0, 0);
        check(i_ext_mem_model.ds2_falls, 1);
        $display("strobe select done");
        // Upper block, wait held low over the address phase
        wr(TARGET_ADDR, 32'h0020_0055);
        wr(CTRL_ADDR, 32'h0000_001E);
        fork
            cyc(32'h0000_0100);
            begin
                wait_n <= 1'b0;
                repeat (8) @(posedge clk_sys);
                wait_n <= 1'b1;
            end
        join
        check(i_ext_mem_model.as_cnt - a0, 8);
        check(i_ext_mem_model.ds_falls - f0, 1);
        check(addr_high_out, 6'h20);
        check({addr_mid_oe, addr_high_oe}, 7'h7F);
        rd(READ_DATA_ADDR);
        check(v, 32'h0000_003C);
        $display("wait done");
        // No stretch, then latch mode
        wr(CTRL_ADDR, 32'h0000_001C);
        wr(STRETCH_ADDR, 32'h0000_0000);
        wr(CFG_ONE_ADDR, 32'h0000_0010);
        wr(TARGET_ADDR, 32'h0000_00AA);
        cyc(32'h0000_0100);
        check(i_ext_mem_model.as_cnt - a0, 1);
        check(i_ext_mem_model.ds_cnt - d0, 2);
        rd(READ_DATA_ADDR);
        check(v, 32'h0000_00C3);
        wr(CFG_ONE_ADDR, 32'h0000_0050);
        wr(TARGET_ADDR, 32'h0000_1234);
        cyc(32'h0000_0100);
        check(i_ext_mem_model.ds_falls - f0, 1);
        rd(READ_DATA_ADDR);
        check(v, 32'h0000_00A5);
        $display("latch done");
        wr(CTRL_ADDR, 32'h0000_001D);
        repeat (3) @(posedge clk_sys);
        check(strobe_oe, 4'h0);
        wr(CTRL_ADDR, 32'h0000_001C);
        bus_ack <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check(strobe_oe, 4'h0);
        $display("float done");
        results();
    end
endmodule : external_memory_bus_interface_bench
`default_nettype wire
